// File: core/spa_core.sv
module spa_core
    import spa_pkg::*;
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic RESET,
    // Serial port pins
    input wire logic SPI_SCK,
    input wire logic SPI_SEL_N,
    input wire logic SPI_MOSI,
    output logic SPI_MISO,
    output logic SPI_MISO_OE,
    // Interface select strap
    input wire logic [1:0] MODE_SEL_LVL,
    // Status toward the device
    output logic SPI_PORT_EN,
    output logic [2:0] ACTIVE_PAGE,
    output logic EYE_MON_EN
);

    // Two-stage synchronisers; stage one is read by stage two only
    logic sck_m_q, sck_s_q, sck_p_q;
    logic sel_m_q, sel_s_q, sel_p_q;
    logic mosi_m_q, mosi_s_q;
    logic [1:0] mode_m_q, mode_s_q;

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            sck_m_q <= 1'h0;
            sck_s_q <= 1'h0;
            sck_p_q <= 1'h0;
            sel_m_q <= 1'h1;
            sel_s_q <= 1'h1;
            sel_p_q <= 1'h1;
            mosi_m_q <= 1'h0;
            mosi_s_q <= 1'h0;
            mode_m_q <= `SPA_MODE_LVL_L;
            mode_s_q <= `SPA_MODE_LVL_L;
        end else begin
            sck_m_q <= SPI_SCK;
            sck_s_q <= sck_m_q;
            sck_p_q <= sck_s_q;
            sel_m_q <= SPI_SEL_N;
            sel_s_q <= sel_m_q;
            sel_p_q <= sel_s_q;
            mosi_m_q <= SPI_MOSI;
            mosi_s_q <= mosi_m_q;
            mode_m_q <= MODE_SEL_LVL;
            mode_s_q <= mode_m_q;
        end
    end

    // Strap capture a few cycles after release, once synchronised
    logic [1:0] strap_cnt_q;
    logic strap_done_q;
    logic spi_en_q;
    wire strap_take = !strap_done_q && (strap_cnt_q == `SPA_STRAP_WAIT);

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'h0;
            spi_en_q <= 1'h0;
        end else begin
            if (!strap_done_q && !strap_take) begin
                strap_cnt_q <= strap_cnt_q + 2'h1;
            end
            if (strap_take) begin
                strap_done_q <= 1'h1;
                spi_en_q <= (mode_s_q == `SPA_MODE_LVL_F);
            end
        end
    end

    // Frame events
    wire sck_rise = sck_s_q && !sck_p_q;
    wire sel_rise = sel_s_q && !sel_p_q;
    wire shift_en = spi_en_q && sck_rise && !sel_s_q;
    wire commit_en = spi_en_q && sel_rise;

    // Shift register and decode of the frame it holds
    spa_frame_t shift_q, shift_d;
    logic [7:0] page_sel_q;
    logic [7:0] lock_mon_q;
    logic miso_q;
    logic [7:0] mem_q [0:`SPA_MEM_WORDS-1];

    wire is_write = commit_en && (shift_q.rw == `SPA_RW_WRITE);
    wire is_read = commit_en && (shift_q.rw == `SPA_RW_READ);
    wire hit_page_sel = (shift_q.addr == `SPA_ADDR_PAGE_SEL);
    wire spa_page_t cur_page = spa_page_of(page_sel_q[`SPA_PAGE_FIELD]);
    wire hit_lock_mon = (cur_page == SPA_PG_CTRL) && (shift_q.addr == `SPA_ADDR_LOCK_MON);
    wire page_ok = (cur_page != SPA_PG_NONE);
    wire [9:0] mem_idx = {cur_page, shift_q.addr};
    wire [7:0] mem_rd = mem_q[mem_idx];
    wire [7:0] rd_data = hit_page_sel ? page_sel_q :
                         hit_lock_mon ? lock_mon_q :
                         page_ok ? mem_rd : 8'h00;

    // Only the flag and address steer a read; trailing bits are dropped
    always_comb begin
        shift_d = shift_q;
        if (shift_en) begin
            shift_d = spa_frame_t'({shift_q[`SPA_FRAME_LOW], mosi_s_q});
        end else if (is_read) begin
            shift_d = '{rw: `SPA_RW_READ, addr: shift_q.addr, data: rd_data};
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            shift_q <= '0;
            miso_q <= `SPA_IDLE_BIT;
        end else begin
            shift_q <= shift_d;
            miso_q <= shift_q.rw;
        end
    end

    always_ff @(posedge REF_CLK or posedge RESET) begin
        if (RESET) begin
            page_sel_q <= `SPA_PAGE_SEL_RESET;
            lock_mon_q <= `SPA_LOCK_MON_RESET;
        end else begin
            if (is_write && hit_page_sel) begin
                page_sel_q <= shift_q.data;
            end
            if (is_write && !hit_page_sel && hit_lock_mon) begin
                lock_mon_q <= shift_q.data;
            end
        end
    end

    // Page storage holds data only, so it carries no reset
    always_ff @(posedge REF_CLK) begin
        if (is_write && !hit_page_sel && !hit_lock_mon && page_ok) begin
            mem_q[mem_idx] <= shift_q.data;
        end
    end

    // Enable follows the pin with no clock so the first bit is ready in time
    assign SPI_MISO_OE = spi_en_q && !SPI_SEL_N;
    assign SPI_MISO = miso_q;
    assign SPI_PORT_EN = spi_en_q;
    assign ACTIVE_PAGE = page_sel_q[`SPA_PAGE_FIELD];
    assign EYE_MON_EN = lock_mon_q[`SPA_LOCK_MON_EN_BIT];

    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (RESET);

    shift_in_a: assert property (shift_en |=>
        shift_q[0] == $past(mosi_s_q) && shift_q[16:1] == $past(shift_q[15:0]))
        else $error("shift register did not take the sampled input bit");

    sel_hold_a: assert property (sel_s_q && sel_p_q |=> $stable(shift_q))
        else $error("shift register moved while select was high");

    page_commit_a: assert property (is_write && hit_page_sel |=>
        page_sel_q == $past(shift_q.data))
        else $error("page select write not committed at frame end");

    no_early_a: assert property (!commit_en |=> $stable(page_sel_q))
        else $error("page select changed outside a frame end");

    read_load_a: assert property (is_read |=> shift_q.rw &&
        shift_q.addr == $past(shift_q.addr) && shift_q.data == $past(rd_data))
        else $error("read result not loaded behind flag and address");

    miso_follow_a: assert property (##1 SPI_MISO == $past(shift_q.rw))
        else $error("serial output does not follow the shift register");

    oe_low_a: assert property (SPI_SEL_N || !spi_en_q |-> !SPI_MISO_OE)
        else $error("output driven while select high or port disabled");

    mode_gate_a: assert property (!spi_en_q |=> $stable(page_sel_q) && $stable(shift_q))
        else $error("port reacted while interface strap was not floating");

    lock_mon_a: assert property (is_write && hit_lock_mon && !hit_page_sel |=>
        EYE_MON_EN == $past(shift_q.data[7]))
        else $error("lock monitor enable did not take the written bit");

    ctrl_page_a: assert property (ACTIVE_PAGE == `SPA_PAGE_CTRL |->
        cur_page == SPA_PG_CTRL)
        else $error("code 100 did not select the control page");

    cfg_page_a: assert property (ACTIVE_PAGE == `SPA_PAGE_CFG |->
        cur_page == SPA_PG_CFG)
        else $error("code 101 did not select the configuration page");

    write_cov_c: cover property (is_write && hit_page_sel);
    read_cov_c: cover property (is_read ##[1:300] is_read);
    lock_cov_c: cover property (is_write && hit_lock_mon);
    cfg_cov_c: cover property (cur_page == SPA_PG_CFG && is_write);

endmodule

// File: core/spa_params.svh
`ifndef SPA_PARAMS_SVH
`define SPA_PARAMS_SVH

// Frame geometry
`define SPA_FRAME_BITS 17
`define SPA_FRAME_MSB 16
`define SPA_FRAME_LOW 15:0

// Register addresses
`define SPA_ADDR_PAGE_SEL 8'hFF
`define SPA_ADDR_LOCK_MON 8'h3E

// Page select field and codes
`define SPA_PAGE_FIELD 2:0
`define SPA_PAGE_GLOBAL 3'h0
`define SPA_PAGE_CTRL 3'h4
`define SPA_PAGE_CFG 3'h5

// Reset values
`define SPA_PAGE_SEL_RESET 8'h00
`define SPA_LOCK_MON_RESET 8'h80
`define SPA_LOCK_MON_EN_BIT 7

// Strap sampling of the interface select pin
`define SPA_MODE_LVL_L 2'h0
`define SPA_MODE_LVL_R 2'h1
`define SPA_MODE_LVL_F 2'h2
`define SPA_MODE_LVL_H 2'h3
`define SPA_STRAP_WAIT 2'h3

// Storage for the three pages
`define SPA_MEM_WORDS 768
`define SPA_RW_READ 1'h1
`define SPA_RW_WRITE 1'h0
`define SPA_IDLE_BIT 1'h0

`endif

// File: core/spa_pkg.sv
`include "spa_params.svh"

package spa_pkg;

    // One 17-bit frame, shifted most significant first
    typedef struct packed {
        logic rw;
        logic [7:0] addr;
        logic [7:0] data;
    } spa_frame_t;

    typedef enum logic [1:0] {
        SPA_PG_GLOBAL = 2'h0,
        SPA_PG_CTRL = 2'h1,
        SPA_PG_CFG = 2'h2,
        SPA_PG_NONE = 2'h3
    } spa_page_t;

    function automatic spa_page_t spa_page_of(input logic [2:0] code);
        spa_page_t pg;
        pg = SPA_PG_NONE;
        if (code == `SPA_PAGE_GLOBAL) begin
            pg = SPA_PG_GLOBAL;
        end else if (code == `SPA_PAGE_CTRL) begin
            pg = SPA_PG_CTRL;
        end else if (code == `SPA_PAGE_CFG) begin
            pg = SPA_PG_CFG;
        end
        return pg;
    endfunction

endpackage

// File: dv/spa_host.sv
module spa_host (
    // Host timing
    input wire logic clk,
    // Serial pins
    output logic sck,
    output logic sel_n,
    output logic mosi,
    input wire logic miso
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        sck = 1'h0;
        sel_n = 1'h1;
        mosi = 1'h0;
    end
    // One frame; each phase is 8 cycles so the device sync chain keeps up
    task automatic xfer(input logic [16:0] tx, output logic [16:0] rx);
        @(negedge clk);
        sel_n = 1'h0;
        for (int i = 16; i >= 0; i--) begin
            mosi = tx[i];
            repeat (8) @(negedge clk);
            sck = 1'h1;
            rx[i] = miso;
            repeat (8) @(negedge clk);
            sck = 1'h0;
        end
        // Toggle before select release so a stale bit never looks valid
        mosi = ~mosi;
        repeat (8) @(negedge clk);
        sel_n = 1'h1;
        repeat (8) @(negedge clk);
    endtask
endmodule

// File: dv/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import spa_pkg::*;
    logic ref_clk = 1'h0;
    logic reset = 1'h1;
    logic [1:0] mode_lvl = 2'h3;
    logic spi_on = 1'h0;
    wire sck, sel_n, mosi;
    logic miso, miso_oe, port_en, eye_mon;
    logic [2:0] act_page;
    wire miso_w = miso_oe ? miso : ~miso;
    int n_mismatch = 0;
    int comparisons = 0;
    int seed = 34622;
    logic [7:0] pg, a, d;
    logic [7:0] mem [int];
    logic [16:0] prev, rx;
    always #5 ref_clk = ~ref_clk;
    spa_core dut (.REF_CLK(ref_clk), .RESET(reset), .SPI_SCK(sck), .SPI_SEL_N(sel_n),
        .SPI_MOSI(mosi), .SPI_MISO(miso), .SPI_MISO_OE(miso_oe), .MODE_SEL_LVL(mode_lvl),
        .SPI_PORT_EN(port_en), .ACTIVE_PAGE(act_page), .EYE_MON_EN(eye_mon));
    spa_host host (.clk(ref_clk), .sck(sck), .sel_n(sel_n), .mosi(mosi), .miso(miso_w));
    task automatic check(string what, logic [16:0] exp, logic [16:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic print_verdict();
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    function automatic logic valid_pg();
        return pg[2:0] inside {3'h0, 3'h4, 3'h5};
    endfunction
    function automatic logic [7:0] exp_rd(logic [7:0] adr);
        if (adr == 8'hFF) return pg;
        if (!valid_pg()) return 8'h00;
        return mem[int'({pg[2:0], adr})];
    endfunction
    always @(negedge sel_n) begin
        #1 check("oe", {16'h0000, spi_on}, {16'h0000, miso_oe});
    end
    task automatic do_reset(logic [1:0] lvl);
        mode_lvl = lvl;
        reset = 1'h1;
        repeat (6) @(negedge ref_clk);
        reset = 1'h0;
        repeat (12) @(negedge ref_clk);
        spi_on = (lvl == 2'h2);
        pg = 8'h00;
        prev = 17'h00000;
        mem.delete();
        mem[int'(11'h43E)] = 8'h80;
    endtask
    task automatic xfer(logic rw, logic [7:0] adr, logic [7:0] dat);
        host.xfer({rw, adr, dat}, rx);
        check("frame", prev, rx);
        if (rw) prev = {1'h1, adr, exp_rd(adr)};
        else begin
            prev = {rw, adr, dat};
            if (adr == 8'hFF) pg = dat;
            else if (valid_pg()) mem[int'({pg[2:0], adr})] = dat;
        end
        repeat (6) @(negedge ref_clk);
        check("oe idle", 17'h00000, {16'h0000, miso_oe});
        check("page", {14'h0000, pg[2:0]}, {14'h0000, act_page});
    endtask
    task automatic rd(logic [7:0] adr);
        xfer(1'h1, adr, 8'hFF);
        xfer(1'h1, 8'hFF, 8'hFF);
    endtask
    initial begin
        repeat (100000) @(posedge ref_clk);
        n_mismatch++;
        print_verdict();
    end
    initial begin
        do_reset(2'h3);
        host.xfer({1'h0, 8'hFF, 8'h05}, rx);
        repeat (6) @(negedge ref_clk);
        check("strap off", 17'h00000, {13'h0000, port_en, act_page});
        do_reset(2'h2);
        check("reset", 17'h00006, {14'h0000, port_en, eye_mon, act_page[0]});
        for (int i = 0; i < 12; i++) begin
            d = 8'($random(seed));
            a = (i < 3) ? 8'h3E : 8'($random(seed));
            if (a == 8'hFF) a = 8'hFE;
            xfer(1'h0, 8'hFF, (i < 4) ? ((i % 2) ? 8'h05 : 8'h04) : d);
            // Write before reading so the page store never shifts out unknown bits
            xfer(1'h0, a, d);
            rd(a);
            rd(a);
        end
        xfer(1'h0, 8'hFF, 8'h04);
        xfer(1'h0, 8'h3E, 8'h00);
        check("monitor", 17'h00000, {16'h0000, eye_mon});
        rd(8'h3E);
        xfer(1'h0, 8'h3E, 8'h80);
        check("monitor", 17'h00001, {16'h0000, eye_mon});
        xfer(1'h0, 8'hFF, 8'h05);
        rd(8'hFF);
        print_verdict();
    end
endmodule
